// file: rtl/ntcas_pkg.sv
// Purpose: shared constants and types of the thermistor alarm sequencer
// Assumes: 40 MHz ref_clk, one-second tick
// Notes: all counts of seconds are counts of ticks
package ntcas_pkg;
  // ==========================================================
  // sizes
  localparam int N_SENS = 6;
  localparam int N_SENS_PULLEY = 4;
  localparam int TW = 9;
  localparam int VW = 13;
  localparam int AW = 6;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 1000000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_S = 1;
  localparam int AVG_S = 5;
  localparam int ROT_S = 3;
  localparam int ALM_DLY_S = 10;
  localparam int STOP_DEF_S = 60;
  localparam int STOP_MAX_S = 180;
  localparam int AVG_TICKS = AVG_S / TICK_S;
  localparam int ROT_TICKS = ROT_S / TICK_S;
  localparam int ALM_TICKS = ALM_DLY_S / TICK_S;
  // ==========================================================
  // temperature scale
  localparam int TEMP_MAX_C = 110;
  localparam int FAHR_MUL = 9;
  localparam int FAHR_DIV = 5;
  localparam int FAHR_OFS = 32;
  // ==========================================================
  // register map
  localparam logic [AW-1:0] REG_CTRL = 6'h00;
  localparam logic [AW-1:0] REG_STOP = 6'h04;
  localparam logic [AW-1:0] REG_STAT = 6'h08;
  localparam logic [AW-1:0] REG_DISP = 6'h0c;
  localparam logic [AW-1:0] REG_THR0 = 6'h10;
  localparam int CTRL_FAHR = 4;
  localparam int CTRL_IMM = 5;
  localparam int CTRL_PUL = 6;
  localparam int STAT_OPN = 8;
  localparam int STAT_OVR = 16;
  localparam int STAT_ARLY = 24;
  localparam int STAT_SRLY = 25;
  localparam int STAT_VIEW = 26;
  localparam int DISP_SCR = 16;
  localparam int DISP_SEL = 20;
  localparam int DISP_MARK = 23;
  localparam int DISP_CD = 24;
  localparam logic [7:0] THR_RST = 8'h50;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // display codes
  localparam logic [1:0] MK_NONE = 2'h0;
  localparam logic [1:0] MK_OVR = 2'h1;
  localparam logic [1:0] MK_OPN = 2'h2;
  localparam logic [1:0] MK_EMPTY = 2'h3;
  typedef enum logic [1:0] {V_ELEV = 2'b01, V_TEMP = 2'b10} ntcas_view_type;
  typedef enum logic [3:0] {
    SC_VALUE = 4'b0001,
    SC_WARN = 4'b0010,
    SC_COUNT = 4'b0100,
    SC_STOPPED = 4'b1000
  } ntcas_scr_type;
endpackage

// file: rtl/ntcas_tick.sv
// Purpose: one-second enable pulse from ref_clk
// Assumes: CYCLES at least 2
// Notes: pulse is one clock wide
`timescale 1ns/1ps
module ntcas_tick #(
  parameter int CYCLES = ntcas_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // enable out
  output logic tick
);
  import ntcas_pkg::*;
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } ntcas_tick_st_type;
  ntcas_tick_st_type r, n;

  initial if (CYCLES < 2) $error("tick divider needs at least 2 cycles");

  // ==========================================================
  // divider
  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (r.cnt == 32'(CYCLES - 1)) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + 32'h1;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = r.tick;
endmodule

// file: rtl/ntcas_avg.sv
// Purpose: five-second block average per thermistor
// Assumes: one sample per tick
// Notes: disabled sensors hold a negative average
`timescale 1ns/1ps
module ntcas_avg #(
  parameter int N = ntcas_pkg::N_SENS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tick,
  // samples
  input wire logic [N-1:0] en,
  input wire logic [N-1:0][ntcas_pkg::TW-1:0] temp_in,
  // averages
  output logic [N-1:0][ntcas_pkg::TW-1:0] avg
);
  import ntcas_pkg::*;
  localparam int SW = TW + 3;
  typedef struct packed {
    logic [2:0] cnt;
    logic [N-1:0][SW-1:0] sum;
    logic [N-1:0][TW-1:0] avg;
  } ntcas_avg_st_type;
  ntcas_avg_st_type r, n;

  initial if (N < 1 || N > 8) $error("sensor count out of range");

  // ==========================================================
  // accumulate and divide each window
  always_comb begin
    logic [SW-1:0] s;
    s = '0;
    n = r;
    if (tick) begin
      n.cnt = (r.cnt == 3'(AVG_TICKS - 1)) ? 3'h0 : r.cnt + 3'h1;
      for (int i = 0; i < N; i++) begin
        s = r.sum[i] + {{(SW-TW){temp_in[i][TW-1]}}, temp_in[i]};
        if (r.cnt == 3'(AVG_TICKS - 1)) begin
          n.avg[i] = TW'($signed(s) / $signed(SW'(AVG_TICKS)));
          n.sum[i] = '0;
        end else begin
          n.sum[i] = s;
        end
      end
    end
    for (int i = 0; i < N; i++) begin
      if (!en[i]) begin
        n.sum[i] = '0;
        n.avg[i] = '1;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r.cnt <= '0;
      r.sum <= '0;
      r.avg <= '1;
    end else begin
      r <= n;
    end
  end

  assign avg = r.avg;
endmodule

// file: rtl/ntcas_seq.sv
// Purpose: thermistor alarm sequencer with display arbitration
// Assumes: keys and alarms synchronous to ref_clk, AXI4-Lite slave
// Notes: stop_relay high means the stop relay is operated
`timescale 1ns/1ps
// Contract
// - enter temperature view on A+C, C in menu selection, or after save.
// - A and B step through sensors, limited to programmed count.
// - shown values in Celsius or Fahrenheit per unit setting.
// - watch programmed sensors for high, open and over-range alarms.
// - over-range sensor shows over-range marker instead of value.
// - open sensor shows open-circuit marker instead of value.
// - alarm cycles value, warning, countdown screens every 3 s.
// - countdown drops each second; at zero stop relay and stopped screen.
// - immediate-stop option operates stop relay at once on hot bearing.
// - stop countdown shares nothing with elevator countdown.
// - temperature alarm takes display from elevator information.
// - elevator alarm takes display from temperature information.
// - elevator alarm wins; temperature alarm shows after it clears.
// - average over 5 s; negative average means open circuit.
// - only positive thresholds accepted; negatives still measured.
// - alarm relay operates a fixed 10 s after detection.
// - stop delay defaults to 60 s, adjustable 0 to 180 s.
// - pulley and chute inputs in use limit sensor count to 4.
// - sensor count ranges from zero to six.
// - without immediate option hot bearing stops after stop delay.
module ntcas_seq #(
  parameter int N = ntcas_pkg::N_SENS,
  parameter int TICK_CYCLES = ntcas_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // axi4-lite write address and data
  input wire logic [ntcas_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ntcas_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // thermistor readings in celsius
  input wire logic [N-1:0][ntcas_pkg::TW-1:0] temp_in,
  // keypad and unit events
  input wire logic key_a,
  input wire logic key_b,
  input wire logic key_c,
  input wire logic menu_sel_view,
  input wire logic save_done,
  input wire logic elev_alarm,
  // relays
  output logic alarm_relay,
  output logic stop_relay,
  // display
  output logic disp_temp,
  output logic [3:0] disp_screen,
  output logic [2:0] disp_sensor,
  output logic [ntcas_pkg::VW-1:0] disp_value,
  output logic [1:0] disp_marker,
  output logic [7:0] disp_countdown
);
  import ntcas_pkg::*;

  typedef struct packed {
    logic awv;
    logic [AW-1:0] awa;
    logic wv;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] cnt;
    logic fahr;
    logic imm;
    logic pulley;
    logic [7:0] stop_dly;
    logic [N-1:0][7:0] thr;
    ntcas_view_type view;
    ntcas_scr_type scr;
    logic [2:0] sel;
    logic [1:0] rot;
    logic [3:0] alm_cnt;
    logic [7:0] stop_cnt;
    logic alarm_relay;
    logic stop_relay;
    logic alm_prev;
    logic [2:0] keys_prev;
    logic [VW-1:0] d_val;
    logic [1:0] d_mark;
  } ntcas_st_type;
  ntcas_st_type r, n;

  initial if (N < 1 || N > 6) $error("sequencer serves one to six sensors");
  initial if (TICK_CYCLES < 2) $error("tick period too short");

  logic tick;
  logic [N-1:0] en, opn, ovr, hot;
  logic [N-1:0][TW-1:0] avg;

  // ==========================================================
  // one-second tick and averaging
  // one-second tick
  ntcas_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(tick)
  );

  ntcas_avg #(.N(N)) u_avg (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(tick),
    .en(en),
    .temp_in(temp_in),
    .avg(avg)
  );

  // ==========================================================
  // per-sensor classification
  for (genvar i = 0; i < N; i++) begin : g_cls
    assign en[i] = 3'(i) < r.cnt;
    assign opn[i] = en[i] & avg[i][TW-1];
    assign ovr[i] = en[i] & ~opn[i] & ($signed(avg[i]) > $signed(TW'(TEMP_MAX_C)));
    assign hot[i] = en[i] & ~opn[i] & ~ovr[i] & ($signed(avg[i]) > $signed({1'b0, r.thr[i]}));
  end

  // ==========================================================
  // next state
  always_comb begin
    logic [2:0] keys, kr, cmax, wcnt, first;
    logic [3:0] widx, ridx;
    logic combo, alm_any, hot_any;
    logic [TW-1:0] a;
    logic [VW-1:0] c;
    keys = {key_c, key_b, key_a};
    kr = keys & ~r.keys_prev;
    combo = key_a & key_c & (kr[0] | kr[2]);
    alm_any = |(opn | ovr | hot);
    hot_any = |hot;
    cmax = '0;
    wcnt = '0;
    first = '0;
    widx = '0;
    ridx = '0;
    a = '0;
    c = '0;
    n = r;
    n.keys_prev = keys;
    n.alm_prev = alm_any;

    // axi address and data capture, either order
    if (s_axi_awvalid && !r.awv && !r.bvalid) begin
      n.awv = 1'b1;
      n.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.wv && !r.bvalid) begin
      n.wv = 1'b1;
      n.wd = s_axi_wdata;
      n.ws = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // register write once both halves are held
    if (r.awv && r.wv && !r.bvalid) begin
      n.awv = 1'b0;
      n.wv = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      widx = 4'(r.awa[AW-1:2] - REG_THR0[AW-1:2]);
      if (r.awa == REG_CTRL) begin
        if (r.ws[0]) begin
          n.fahr = r.wd[CTRL_FAHR];
          n.imm = r.wd[CTRL_IMM];
          n.pulley = r.wd[CTRL_PUL];
          cmax = r.wd[CTRL_PUL] ? 3'(N_SENS_PULLEY) : 3'(N);
          wcnt = r.wd[2:0];
          n.cnt = (wcnt > cmax) ? cmax : wcnt;
        end
      end else if (r.awa == REG_STOP) begin
        if (r.ws[0] && r.wd[7:0] <= 8'(STOP_MAX_S)) begin
          n.stop_dly = r.wd[7:0];
        end
      end else if (r.awa == REG_STAT || r.awa == REG_DISP) begin
        n.bresp = RESP_OKAY;
      end else if (r.awa >= REG_THR0 && widx < 4'(N) && r.awa[1:0] == 2'h0) begin
        if (r.ws[0] && r.wd[7:0] != 8'h0 && r.wd[7:0] <= 8'(TEMP_MAX_C)) begin
          n.thr[widx[2:0]] = r.wd[7:0];
        end
      end else begin
        n.bresp = RESP_SLVERR;
      end
    end

    // pulley inputs cap count at four
    if (n.pulley && n.cnt > 3'(N_SENS_PULLEY)) begin
      n.cnt = 3'(N_SENS_PULLEY);
    end

    // axi read
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      ridx = 4'(s_axi_araddr[AW-1:2] - REG_THR0[AW-1:2]);
      if (s_axi_araddr == REG_CTRL) begin
        n.rdata[2:0] = r.cnt;
        n.rdata[CTRL_FAHR] = r.fahr;
        n.rdata[CTRL_IMM] = r.imm;
        n.rdata[CTRL_PUL] = r.pulley;
      end else if (s_axi_araddr == REG_STOP) begin
        n.rdata[7:0] = r.stop_dly;
      end else if (s_axi_araddr == REG_STAT) begin
        n.rdata[N-1:0] = hot;
        n.rdata[STAT_OPN +: N] = opn;
        n.rdata[STAT_OVR +: N] = ovr;
        n.rdata[STAT_ARLY] = r.alarm_relay;
        n.rdata[STAT_SRLY] = r.stop_relay;
        n.rdata[STAT_VIEW] = (r.view == V_TEMP);
      end else if (s_axi_araddr == REG_DISP) begin
        n.rdata[VW-1:0] = r.d_val;
        n.rdata[DISP_SCR +: 4] = r.scr;
        n.rdata[DISP_SEL +: 3] = r.sel;
        n.rdata[DISP_MARK +: 1] = (r.d_mark != MK_NONE);
        n.rdata[DISP_CD +: 8] = r.stop_cnt;
      end else if (s_axi_araddr >= REG_THR0 && ridx < 4'(N) && s_axi_araddr[1:0] == 2'h0) begin
        n.rdata[7:0] = r.thr[ridx[2:0]];
      end else begin
        n.rresp = RESP_SLVERR;
      end
    end

    // alarm and stop timers
    // own countdown only
    if (!alm_any) begin
      n.alm_cnt = '0;
      n.alarm_relay = 1'b0;
      n.stop_relay = 1'b0;
      n.stop_cnt = r.stop_dly;
    end else begin
      if (r.alm_cnt == 4'(ALM_TICKS)) begin
        n.alarm_relay = 1'b1;
      end else if (tick) begin
        n.alm_cnt = r.alm_cnt + 4'h1;
      end
      if (r.imm && hot_any) begin
        n.stop_relay = 1'b1;
      end else if (r.stop_cnt == 8'h0) begin
        n.stop_relay = 1'b1;
      end else if (tick) begin
        n.stop_cnt = r.stop_cnt - 8'h1;
      end
    end

    if ((r.view == V_ELEV && combo) || (menu_sel_view && kr[2]) || save_done) begin
      n.view = V_TEMP;
    end else if (r.view == V_TEMP && combo) begin
      n.view = V_ELEV;
    end
    if (r.view == V_TEMP && !combo) begin
      if (kr[0] && 4'(r.sel) + 4'h1 < 4'(r.cnt)) begin
        n.sel = r.sel + 3'h1;
      end else if (kr[1] && r.sel != 3'h0) begin
        n.sel = r.sel - 3'h1;
      end
    end

    // point at the first alarmed sensor when an alarm arises
    for (int i = N - 1; i >= 0; i--) begin
      if (opn[i] | ovr[i] | hot[i]) begin
        first = 3'(i);
      end
    end
    if (alm_any && !r.alm_prev) begin
      n.sel = first;
      n.rot = '0;
    end

    if (elev_alarm) begin
      n.view = V_ELEV;
    end else if (alm_any) begin
      n.view = V_TEMP;
    end
    if (n.sel >= n.cnt) begin
      n.sel = '0;
    end

    if (!alm_any) begin
      n.scr = SC_VALUE;
      n.rot = '0;
    end else if (n.stop_relay) begin
      n.scr = SC_STOPPED;
    end else if (tick) begin
      if (r.rot == 2'(ROT_TICKS - 1)) begin
        n.rot = '0;
        unique case (r.scr)
          SC_VALUE: n.scr = SC_WARN;
          SC_WARN: n.scr = SC_COUNT;
          SC_COUNT: n.scr = SC_VALUE;
          default: n.scr = SC_VALUE;
        endcase
      end else begin
        n.rot = r.rot + 2'h1;
      end
    end

    a = avg[n.sel];
    c = {{(VW-TW){a[TW-1]}}, a};
    n.d_val = r.fahr ? VW'($signed(c) * $signed(VW'(FAHR_MUL)) / $signed(VW'(FAHR_DIV))
      + $signed(VW'(FAHR_OFS))) : c;
    if (ovr[n.sel]) begin
      n.d_mark = MK_OVR;
    end else if (opn[n.sel]) begin
      n.d_mark = MK_OPN;
    end else if (r.cnt == 3'h0) begin
      n.d_mark = MK_EMPTY;
    end else begin
      n.d_mark = MK_NONE;
    end
  end

  // ==========================================================
  // state register
  // reset clears alarm timer and alarms, loads stop countdown with default
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
      r.view <= V_ELEV;
      r.scr <= SC_VALUE;
      r.stop_dly <= 8'(STOP_DEF_S);
      r.stop_cnt <= 8'(STOP_DEF_S);
      r.thr <= {N{THR_RST}};
      r.d_mark <= MK_EMPTY;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = !r.awv && !r.bvalid;
  assign s_axi_wready = !r.wv && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign alarm_relay = r.alarm_relay;
  assign stop_relay = r.stop_relay;
  assign disp_temp = (r.view == V_TEMP);
  assign disp_screen = r.scr;
  assign disp_sensor = r.sel + 3'h1;
  assign disp_value = r.d_val;
  assign disp_marker = r.d_mark;
  assign disp_countdown = r.stop_cnt;
endmodule

// file: tb/ntcas_sens_model.sv
// Purpose: thermistor bank and keypad facing the sequencer
// Assumes: bench commands temperatures and key levels
// Notes: outputs follow commands one clock later
`timescale 1ns/1ps
module ntcas_sens_model (
  // clock
  input wire logic ref_clk,
  // commands from the bench
  input wire logic [ntcas_pkg::N_SENS-1:0][ntcas_pkg::TW-1:0] set_temp,
  input wire logic [2:0] key_cmd,
  // towards the sequencer
  output logic [ntcas_pkg::N_SENS-1:0][ntcas_pkg::TW-1:0] temp_in,
  output logic key_a,
  output logic key_b,
  output logic key_c
);
  import ntcas_pkg::*;
  typedef struct packed {
    logic [N_SENS-1:0][TW-1:0] temp;
    logic [2:0] keys;
  } ntcas_model_type;
  ntcas_model_type st_r;
  ntcas_model_type st_nxt;
  // next state follows the commands
  always_comb begin
    st_nxt = st_r;
    st_nxt.temp = set_temp;
    st_nxt.keys = key_cmd;
  end
  // sensors and keys change only after a clock edge
  always_ff @(posedge ref_clk) begin
    st_r <= st_nxt;
  end
  assign temp_in = st_r.temp;
  assign {key_c, key_b, key_a} = st_r.keys;
endmodule

// file: tb/ntcas_seq_props.sv
// Purpose: port checks of the alarm sequencer
// Assumes: one clock, sync reset
// Notes: bound into every ntcas_seq
`timescale 1ns/1ps
module ntcas_seq_props #(
  parameter int N = 6
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // unit alarm and outputs
  input wire logic elev_alarm,
  input wire logic stop_relay,
  input wire logic disp_temp,
  input wire logic [3:0] disp_screen,
  input wire logic [2:0] disp_sensor,
  input wire logic [7:0] disp_countdown
);
  import ntcas_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // display screens
  sequence s_val_to_warn;
    $past(disp_screen) == SC_VALUE && disp_screen == SC_WARN;
  endsequence
  property p_onehot;
    $onehot(disp_screen);
  endproperty
  a_onehot: assert property (p_onehot) else $error("screen code not one-hot");
  property p_rot;
    s_val_to_warn |=> (disp_screen != SC_COUNT) [*8];
  endproperty
  a_rot: assert property (p_rot) else $error("screen rotated too fast");
  property p_stop_scr;
    $rose(stop_relay) && disp_temp |-> ##[0:2] disp_screen == SC_STOPPED;
  endproperty
  a_stop_scr: assert property (p_stop_scr) else $error("no stopped screen");
  property p_cd_step;
    $past(disp_screen) == SC_COUNT && disp_screen == SC_COUNT && disp_countdown != $past(disp_countdown)
      |-> disp_countdown == $past(disp_countdown) - 8'h01;
  endproperty
  a_cd_step: assert property (p_cd_step) else $error("countdown step not one");
  property p_cd_max;
    disp_countdown <= 8'hb4;
  endproperty
  a_cd_max: assert property (p_cd_max) else $error("countdown above limit");
  property p_sel;
    disp_sensor >= 3'h1 && disp_sensor <= N;
  endproperty
  a_sel: assert property (p_sel) else $error("shown sensor out of range");
  property p_elev;
    elev_alarm [*2] |-> !disp_temp;
  endproperty
  a_elev: assert property (p_elev) else $error("elevator alarm lost display");
  // ==========================================================
  // bus
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule
bind ntcas_seq ntcas_seq_props #(.N(N)) chk (.ref_clk, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .elev_alarm, .stop_relay, .disp_temp, .disp_screen, .disp_sensor, .disp_countdown);

// file: tb/ntcas_seq_bench.sv
// Purpose: self-checking bench of the alarm sequencer
// Assumes: tick shortened to 10 clocks
// Notes: register rows first, then hand tests
`timescale 1ns/1ps
module ntcas_seq_bench;
  import ntcas_pkg::*;
  localparam int TK = 10;
  typedef struct packed {
    logic [5:0] wa;
    logic [7:0] wd;
    logic [1:0] br;
    logic [5:0] ra;
    logic [7:0] rd;
  } ntcas_row_type;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [5:0] s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic [N_SENS-1:0][TW-1:0] set_temp = '0, temp_in;
  logic [2:0] key_cmd = 3'h0;
  logic key_a, key_b, key_c, alarm_relay, stop_relay, disp_temp;
  logic menu_sel_view = 1'h0, save_done = 1'h0, elev_alarm = 1'h0;
  logic [3:0] disp_screen;
  logic [2:0] disp_sensor;
  logic [VW-1:0] disp_value;
  logic [1:0] disp_marker;
  logic [7:0] disp_countdown;
  int miscompares = 0, n_compared = 0, cyc = 0;
  ntcas_row_type rows [10];
  // ==========================================================
  // clock, timeout, parts
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      miscompares++;
      finish_test();
    end
  end
  ntcas_sens_model model (.ref_clk, .set_temp, .key_cmd, .temp_in, .key_a, .key_b, .key_c);
  ntcas_seq #(.N(N_SENS), .TICK_CYCLES(TK)) uut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .temp_in, .key_a, .key_b, .key_c, .menu_sel_view, .save_done,
    .elev_alarm, .alarm_relay, .stop_relay, .disp_temp, .disp_screen, .disp_sensor, .disp_value,
    .disp_marker, .disp_countdown);
  // ==========================================================
  // tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // write: both halves offered together, each dropped when taken
  task automatic axi_wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic axi_rd(input logic [5:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    check("rresp", s_axi_rresp, RESP_OKAY);
    s_axi_rready <= 1'h0;
    @(posedge ref_clk);
  endtask
  // key code is {c, b, a}
  task automatic press(input logic [2:0] k);
    key_cmd <= k;
    repeat (3) @(posedge ref_clk);
    key_cmd <= 3'h0;
    repeat (3) @(posedge ref_clk);
  endtask
  // bring sensor 1 back to normal and wait for the relays to drop
  task automatic cool();
    set_temp[0] <= 9'h019;
    repeat (12 * TK) @(posedge ref_clk);
    for (int i = 0; i < 300 && (alarm_relay || stop_relay); i++) @(posedge ref_clk);
    check("relays released", {alarm_relay, stop_relay}, 2'h0);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    rows = '{'{REG_CTRL, 8'h03, RESP_OKAY, REG_CTRL, 8'h03}, '{REG_CTRL, 8'h07, RESP_OKAY, REG_CTRL, 8'h06},
      '{REG_STOP, 8'hb4, RESP_OKAY, REG_STOP, 8'hb4}, '{REG_STOP, 8'hb5, RESP_OKAY, REG_STOP, 8'hb4},
      '{REG_THR0, 8'h64, RESP_OKAY, REG_THR0, 8'h64}, '{REG_THR0, 8'h00, RESP_OKAY, REG_THR0, 8'h64},
      '{6'h14, 8'hf6, RESP_OKAY, 6'h14, 8'h50}, '{6'h3c, 8'h11, RESP_SLVERR, REG_STOP, 8'hb4},
      '{REG_CTRL, 8'h46, RESP_OKAY, REG_CTRL, 8'h44}, '{REG_CTRL, 8'h06, RESP_OKAY, REG_CTRL, 8'h06}};
    repeat (20) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      axi_wr(rows[i].wa, rows[i].wd, resp);
      check("bresp", resp, rows[i].br);
      axi_rd(rows[i].ra, rd);
      check("readback", rd[7:0], rows[i].rd);
    end
    $display("register rows done");
    rst <= 1'h1;
    repeat (3) @(posedge ref_clk);
    check("relays", {alarm_relay, stop_relay, disp_temp}, 3'h0);
    check("countdown", disp_countdown, 8'h3c);
    check("marker", disp_marker, MK_EMPTY);
    rst <= 1'h0;
    @(posedge ref_clk);
    axi_rd(REG_STOP, rd);
    check("stop delay", rd[7:0], 8'h3c);
    axi_rd(REG_THR0, rd);
    check("threshold", rd[7:0], THR_RST);
    $display("reset test done");
    axi_wr(REG_CTRL, 8'h03, resp);
    axi_wr(REG_STOP, 8'h0f, resp);
    set_temp <= {6{9'h019}};
    repeat (12 * TK) @(posedge ref_clk);
    check("new sensor view", disp_temp, 1'h1);
    press(3'h5);
    press(3'h5);
    check("view", disp_temp, 1'h1);
    check("value", disp_value, 13'h0019);
    press(3'h1);
    press(3'h1);
    press(3'h1);
    check("sensor top", disp_sensor, 3'h3);
    press(3'h2);
    check("sensor down", disp_sensor, 3'h2);
    axi_wr(REG_CTRL, 8'h13, resp);
    repeat (2 * TK) @(posedge ref_clk);
    check("fahrenheit", disp_value, 13'h004d);
    axi_wr(REG_CTRL, 8'h03, resp);
    press(3'h5);
    check("view off", disp_temp, 1'h0);
    menu_sel_view <= 1'h1;
    press(3'h4);
    check("menu entry", disp_temp, 1'h1);
    menu_sel_view <= 1'h0;
    press(3'h5);
    save_done <= 1'h1;
    @(posedge ref_clk);
    save_done <= 1'h0;
    repeat (3) @(posedge ref_clk);
    check("save entry", disp_temp, 1'h1);
    press(3'h5);
    $display("view test done");
    set_temp[0] <= 9'h1fb;
    for (int i = 0; i < 200 && disp_marker !== MK_OPN; i++) @(posedge ref_clk);
    check("open marker", disp_marker, MK_OPN);
    check("auto view", disp_temp, 1'h1);
    check("alarm sensor", disp_sensor, 3'h1);
    set_temp[0] <= 9'h078;
    for (int i = 0; i < 200 && disp_marker !== MK_OVR; i++) @(posedge ref_clk);
    check("over marker", disp_marker, MK_OVR);
    cool();
    $display("marker test done");
    set_temp[0] <= 9'h05a;
    for (int i = 0; i < 200 && disp_countdown !== 8'h0e; i++) @(posedge ref_clk);
    check("countdown start", disp_countdown, 8'h0e);
    repeat (7 * TK) @(posedge ref_clk);
    check("alarm relay early", alarm_relay, 1'h0);
    for (int i = 0; i < 4 * TK && !alarm_relay; i++) @(posedge ref_clk);
    check("alarm relay", alarm_relay, 1'h1);
    check("stop relay early", stop_relay, 1'h0);
    for (int i = 0; i < 8 * TK && !stop_relay; i++) @(posedge ref_clk);
    check("stop relay", stop_relay, 1'h1);
    check("countdown zero", disp_countdown, 8'h00);
    repeat (2) @(posedge ref_clk);
    check("stopped screen", disp_screen, SC_STOPPED);
    elev_alarm <= 1'h1;
    repeat (3) @(posedge ref_clk);
    check("elevator owns", disp_temp, 1'h0);
    elev_alarm <= 1'h0;
    repeat (3) @(posedge ref_clk);
    check("temp returns", disp_temp, 1'h1);
    check("stop kept", stop_relay, 1'h1);
    cool();
    $display("hot test done");
    axi_wr(REG_CTRL, 8'h23, resp);
    set_temp[0] <= 9'h05a;
    for (int i = 0; i < 200 && !stop_relay; i++) @(posedge ref_clk);
    check("immediate stop", stop_relay, 1'h1);
    check("no delay", alarm_relay, 1'h0);
    cool();
    $display("immediate test done");
    finish_test();
  end
endmodule
